// [rtl/pic_ctrl.sv]
/*
  Prioritised interrupt controller: 51 sources, mode 0 single mask bit
  or mode 2 eight-level masking, registered grant to the processor core,
  APB register slave and a summary interrupt of its own events.
  Assumes on-chip requests are levels on pclk, held until serviced;
  pin requests are asynchronous and synchronised here.
*/
// Functional notes
// - Fifty-one sources: nine pin requests and forty-two on-chip requests.
// - Every source has its own vector; NMI 7, pins 16 to 23.
// - Vector address is vector times two normal, times four advanced.
// - Two-bit mode field: 00 selects mode 0, 10 selects mode 2.
// - Mode field values 01 and 11 cannot be set.
// - Mode 0: global mask bit 1 blocks pin and module requests.
// - Mode 2: requests masked by comparing level with mask level.
// - Priority fields give eight levels for request groups.
// - NMI is highest priority and always accepted.
// - Transfer controller activation end uses vector 24.
// - Watchdog 25, refresh compare-match 26, conversion end 28.
// - Timer channel 0: four capture/match, one overflow, vectors 32-36.
// - Timer channels 1 and 2 use vectors 40 to 47.
// - Timer channel 3 vectors 48-52; channels 4 and 5 use 56-63.
// - DMA transfer ends 0A, 0B, 1A, 1B use vectors 72-75.
// - Serial channels: error, rx, tx empty, tx end; 80-87.
module pic_ctrl
  import pic_pkg::*;
(
  input wire logic pclk,                          // APB clock
  input wire logic presetn,                       // async reset, low
  input wire logic ce,                            // clock enable
  input wire logic psel,                          // APB select
  input wire logic penable,                       // APB enable
  input wire logic pwrite,                        // APB direction
  input wire logic [pic_pkg::ADDR_W-1:0] paddr,   // APB address
  input wire logic [31:0] pwdata,                 // APB write data
  output logic [31:0] prdata,                     // APB read data
  output logic pready,                            // APB ready
  output logic pslverr,                           // APB error
  input wire logic nmi_pin,                       // non-maskable pin
  input wire logic [pic_pkg::NUM_EXT-1:0] external_request_lines, // pins
  input wire logic [pic_pkg::NUM_PER-1:0] periph_req, // module requests
  input wire pic_pkg::pic_core_t core,            // core mask state
  output pic_pkg::pic_grant_t grant,              // request to core
  output logic irq                                // own event interrupt
);
  import pic_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic [1:0] nmi_sync;
    logic [1:0][NUM_EXT-1:0] ext_sync;
    logic [1:0] mode;
    logic [NUM_GRP-1:0][2:0] prio;
    logic [STS_W-1:0] sts;
    logic [STS_W-1:0] msk;
    logic [31:0] prdata;
    pic_grant_t grant;
  } pic_state_t;

  pic_state_t st_r;
  pic_state_t st_nxt;

  // ==========================================================
  // Address decode shared by read and write paths
  function automatic logic [4:0] prio_reg(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - OFS_PRIO_BASE;
    if (a >= OFS_PRIO_BASE && off[1:0] == 2'h0 &&
        off[ADDR_W-1:2] < (ADDR_W-2)'(NUM_PRIO_REG)) begin
      prio_reg = {1'b1, off[5:2]};
    end else begin
      prio_reg = 5'h00;
    end
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [4:0] sel;
    sel = prio_reg(a);
    is_mapped = (a == OFS_SYSCTL) || (a == OFS_STATUS) ||
                (a == OFS_MASK) || (a == OFS_CURRENT) || sel[4];
  endfunction

  // ==========================================================
  // Source vector: pins first, then modules in vector order
  logic [NUM_MSK-1:0] src_req;
  logic [NUM_MSK-1:0][2:0] src_lvl;

  assign src_req = {periph_req, st_r.ext_sync[1]};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_MSK; gi++) begin : g_lvl
      assign src_lvl[gi] = st_r.prio[SRC_GRP[gi]];
    end
  endgenerate

  // ==========================================================
  // Arbitration
  logic found;
  logic [5:0] win_idx;
  logic [2:0] win_lvl;
  logic [6:0] win_vec;
  logic elig;

  always_comb begin
    found = 1'b0;
    win_idx = 6'h00;
    win_lvl = 3'h0;
    elig = 1'b0;
    for (int i = 0; i < NUM_MSK; i++) begin
      if (st_r.mode == PIC_MODE2) begin
        elig = src_req[i] && (src_lvl[i] > core.mask_level);
      end else begin
        elig = src_req[i] && !core.ccr_mask;
      end
      // Strict compare keeps the earlier, lower vector on a tie
      if (elig && (!found || (st_r.mode == PIC_MODE2 &&
          src_lvl[i] > win_lvl))) begin
        found = 1'b1;
        win_idx = 6'(i);
        win_lvl = (st_r.mode == PIC_MODE2) ? src_lvl[i] : 3'h0;
      end
    end
    win_vec = SRC_VEC[win_idx];
  end

  // ==========================================================
  // APB
  logic setup;
  logic wr_fire;
  logic [4:0] rsel;
  logic [4:0] wsel;
  logic [STS_W-1:0] sts_set;
  logic [STS_W-1:0] sts_clr;
  logic [6:0] gnt_vec;

  assign setup = psel && !penable;
  assign pready = ce;
  assign pslverr = psel && penable && !is_mapped(paddr);
  assign wr_fire = psel && penable && pwrite && ce && is_mapped(paddr);
  assign rsel = prio_reg(paddr);
  assign wsel = prio_reg(paddr);

  always_comb begin
    st_nxt = st_r;
    sts_set = '0;
    sts_clr = '0;
    gnt_vec = 7'h00;

    // Pin synchronisers; stage 0 feeds stage 1 only
    st_nxt.nmi_sync = {st_r.nmi_sync[0], nmi_pin};
    st_nxt.ext_sync[1] = st_r.ext_sync[0];
    st_nxt.ext_sync[0] = external_request_lines;

    // Grant to the core
    if (st_r.nmi_sync[1]) begin
      // Overrides mode, mask bit and mask level alike
      gnt_vec = VEC_NMI;
      st_nxt.grant.req = 1'b1;
      st_nxt.grant.nmi = 1'b1;
      st_nxt.grant.level = 3'h7;
    end else begin
      gnt_vec = win_vec;
      st_nxt.grant.req = found;
      st_nxt.grant.nmi = 1'b0;
      st_nxt.grant.level = win_lvl;
    end
    if (!st_nxt.grant.req) begin
      gnt_vec = 7'h00;
    end
    st_nxt.grant.vec = gnt_vec;
    if (core.adv_mode) begin
      st_nxt.grant.addr = {7'h00, gnt_vec, 2'h0};
    end else begin
      st_nxt.grant.addr = {8'h00, gnt_vec, 1'h0};
    end

    // Own events
    sts_set[STS_ACK] = core.ack && st_r.grant.req;
    sts_set[STS_NMI] = core.ack && st_r.grant.nmi;

    // Read data captured in the setup cycle
    if (setup) begin
      st_nxt.prdata = 32'h0000_0000;
      case (paddr)
        OFS_SYSCTL: st_nxt.prdata[1:0] = st_r.mode;
        OFS_STATUS: st_nxt.prdata[STS_W-1:0] = st_r.sts;
        OFS_MASK: st_nxt.prdata[STS_W-1:0] = st_r.msk;
        OFS_CURRENT: st_nxt.prdata[13:0] = {st_r.grant.req,
          st_r.grant.nmi, st_r.grant.level, st_r.grant.vec, 2'h0};
        default: begin
          if (rsel[4]) begin
            st_nxt.prdata[PRIO_HI_POS +: 3] = st_r.prio[{rsel[3:0], 1'b0}];
            st_nxt.prdata[PRIO_LO_POS +: 3] = st_r.prio[{rsel[3:0], 1'b1}];
          end
        end
      endcase
    end

    // Writes take effect on the completing access edge
    if (wr_fire) begin
      case (paddr)
        OFS_SYSCTL: begin
          if (pwdata[MODE_LO_POS] == 1'b0) begin
            st_nxt.mode = {pwdata[MODE_HI_POS], 1'b0};
          end else begin
            sts_set[STS_BADMODE] = 1'b1;
          end
        end
        OFS_STATUS: sts_clr = pwdata[STS_W-1:0];
        OFS_MASK: st_nxt.msk = pwdata[STS_W-1:0];
        OFS_CURRENT: begin
          // Read-only view of the grant
        end
        default: begin
          if (wsel[4]) begin
            st_nxt.prio[{wsel[3:0], 1'b0}] = pwdata[PRIO_HI_POS +: 3];
            st_nxt.prio[{wsel[3:0], 1'b1}] = pwdata[PRIO_LO_POS +: 3];
          end
        end
      endcase
    end

    // A new event beats a clear in the same cycle
    st_nxt.sts = (st_r.sts & ~sts_clr) | sts_set;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.nmi_sync <= 2'h0;
      st_r.ext_sync <= '0;
      st_r.mode <= MODE_RST;
      st_r.prio <= {NUM_GRP{PRIO_RST}};
      st_r.sts <= STS_RST;
      st_r.msk <= MASK_RST;
      st_r.prdata <= 32'h0000_0000;
      st_r.grant <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.prdata;
  assign grant = st_r.grant;
  assign irq = |(st_r.sts & st_r.msk);

endmodule

// [rtl/pic_pkg.sv]
/*
  Constants, register map and carrier types of the prioritised interrupt
  controller. Assumes a 32-bit APB slave with a 12-bit byte address.
*/
package pic_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_MSK = 50;          // maskable sources
  localparam int NUM_EXT = 8;           // general external pins
  localparam int NUM_PER = 42;          // on-chip module requests
  localparam int NUM_GRP = 20;          // priority fields
  localparam int NUM_PRIO_REG = 10;     // registers holding two fields
  localparam int ADDR_W = 12;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [11:0] OFS_SYSCTL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_MASK = 12'h008;
  localparam logic [11:0] OFS_CURRENT = 12'h00C;
  localparam logic [11:0] OFS_PRIO_BASE = 12'h010;

  // Field positions
  localparam int MODE_LO_POS = 0;       // int_mode_sel_lo
  localparam int MODE_HI_POS = 1;       // int_mode_sel_hi
  localparam int PRIO_HI_POS = 4;       // even group field
  localparam int PRIO_LO_POS = 0;       // odd group field
  localparam int STS_ACK = 0;           // core took a request
  localparam int STS_BADMODE = 1;       // write of mode 1 or 3 refused
  localparam int STS_NMI = 2;           // core took a non-maskable request
  localparam int STS_W = 3;

  // Reset values
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [2:0] PRIO_RST = 3'h7;
  localparam logic [2:0] STS_RST = 3'h0;
  localparam logic [2:0] MASK_RST = 3'h0;

  // ==========================================================
  // Modes
  typedef enum logic [1:0] {
    PIC_MODE0 = 2'h0,
    PIC_MODE1 = 2'h1,
    PIC_MODE2 = 2'h2,
    PIC_MODE3 = 2'h3
  } pic_mode_t;

  // ==========================================================
  // Vectors, ascending with source index
  localparam logic [6:0] VEC_NMI = 7'h07;
  localparam logic [6:0] SRC_VEC [NUM_MSK] = '{
    7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17,
    7'h18, 7'h19, 7'h1A, 7'h1C,
    7'h20, 7'h21, 7'h22, 7'h23, 7'h24,
    7'h28, 7'h29, 7'h2A, 7'h2B, 7'h2C, 7'h2D, 7'h2E, 7'h2F,
    7'h30, 7'h31, 7'h32, 7'h33, 7'h34,
    7'h38, 7'h39, 7'h3A, 7'h3B, 7'h3C, 7'h3D, 7'h3E, 7'h3F,
    7'h48, 7'h49, 7'h4A, 7'h4B,
    7'h50, 7'h51, 7'h52, 7'h53, 7'h54, 7'h55, 7'h56, 7'h57
  };

  // Priority field that governs each source
  localparam logic [4:0] SRC_GRP [NUM_MSK] = '{
    5'h00, 5'h01, 5'h02, 5'h02, 5'h03, 5'h03, 5'h04, 5'h04,
    5'h05, 5'h06, 5'h07, 5'h09,
    5'h0A, 5'h0A, 5'h0A, 5'h0A, 5'h0A,
    5'h0B, 5'h0B, 5'h0B, 5'h0B, 5'h0C, 5'h0C, 5'h0C, 5'h0C,
    5'h0D, 5'h0D, 5'h0D, 5'h0D, 5'h0D,
    5'h0E, 5'h0E, 5'h0E, 5'h0E, 5'h0F, 5'h0F, 5'h0F, 5'h0F,
    5'h10, 5'h10, 5'h10, 5'h10,
    5'h11, 5'h11, 5'h11, 5'h11, 5'h12, 5'h12, 5'h12, 5'h12
  };

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic ccr_mask;                     // global mask bit
    logic [2:0] mask_level;             // mask_level_field
    logic adv_mode;                     // core in advanced mode
    logic ack;                          // core accepted grant
  } pic_core_t;

  typedef struct packed {
    logic req;
    logic nmi;
    logic [6:0] vec;
    logic [2:0] level;
    logic [15:0] addr;
  } pic_grant_t;

endpackage

// [verif/pic_core_model.sv]
/* Processor core stand-in: mask state and one-cycle acknowledge.
   Assumes the bench sets its controls and it shares pclk. */
module pic_core_model
  import pic_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low
  input wire logic ccr_i, // global mask bit
  input wire logic adv_i, // advanced mode
  input wire logic ack_en, // take grants
  input wire logic [2:0] lvl_i, // mask level
  input wire pic_pkg::pic_grant_t grant, // request in
  output pic_pkg::pic_core_t core // state out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // Core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core <= '0;
    end else begin
      core.ccr_mask <= ccr_i;
      core.mask_level <= lvl_i;
      core.adv_mode <= adv_i;
      // Never two acks in a row: a held grant is taken every other cycle
      core.ack <= ack_en && grant.req && !core.ack;
    end
  end
endmodule

// [verif/pic_ctrl_assertions.sv]
/* Port checker for pic_ctrl.
   Assumes ce is held high and core is registered on pclk. */
module pic_ctrl_assertions
  import pic_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low
  input wire logic ce, // clock enable
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [pic_pkg::ADDR_W-1:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic nmi_pin, // non-maskable pin
  input wire logic irq, // own interrupt
  input wire logic [pic_pkg::NUM_EXT-1:0] external_request_lines, // pins
  input wire logic [pic_pkg::NUM_PER-1:0] periph_req, // modules
  input wire pic_pkg::pic_core_t core, // core state
  input wire pic_pkg::pic_grant_t grant // grant
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // Checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic quiet;
  assign quiet = !nmi_pin && external_request_lines == '0 && periph_req == '0;
  addr_norm_a: assert property (grant.req && !$past(core.adv_mode) |->
    grant.addr == {8'h0, grant.vec, 1'b0}) else $error("normal address");
  addr_adv_a: assert property (grant.req && $past(core.adv_mode) |->
    grant.addr == {7'h0, grant.vec, 2'h0}) else $error("advanced address");
  nmi_vec_a: assert property (grant.nmi |-> grant.req &&
    grant.vec == 7'h07) else $error("nmi vector");
  nmi_take_a: assert property (nmi_pin [*4] |=> grant.nmi)
    else $error("nmi not taken");
  mode0_gate_a: assert property (grant.req && !grant.nmi &&
    grant.level == 3'h0 |-> !$past(core.ccr_mask)) else $error("mask bit");
  level_gate_a: assert property (grant.req && !grant.nmi &&
    grant.level != 3'h0 |-> grant.level > $past(core.mask_level))
    else $error("mask level");
  idle_grant_a: assert property (quiet [*4] |=> !grant.req)
    else $error("grant without source");
  vec_range_a: assert property (grant.req && !grant.nmi |->
    grant.vec inside {[16:87]}) else $error("vector range");
endmodule

bind pic_ctrl pic_ctrl_assertions chk_u (
  .pclk(pclk),
  .presetn(presetn),
  .ce(ce),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .nmi_pin(nmi_pin),
  .irq(irq),
  .external_request_lines(external_request_lines),
  .periph_req(periph_req),
  .core(core),
  .grant(grant)
);

// [verif/pic_ctrl_bench.sv]
/* Self-checking bench for pic_ctrl with core model and APB tasks.
   Assumes ce held high, so the slave answers without waits. */
module pic_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import pic_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic nmi_pin = 0, condition_code_register = 0, adv = 0, ack_en = 0, slv, pready, pslverr, irq;
  logic [2:0] lvl = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic [7:0] ext = 0;
  logic [41:0] preq = 0;
  pic_core_t core;
  pic_grant_t grant;
  int err_total = 0, n_checks = 0;

  pic_ctrl dut_u (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .nmi_pin,
    .external_request_lines(ext), .periph_req(preq), .core, .grant, .irq);
  pic_core_model core_u (.pclk, .presetn, .ccr_i(condition_code_register), .adv_i(adv),
    .ack_en, .lvl_i(lvl), .grant, .core);

  initial forever #5 pclk = ~pclk;

  // ====
  // Helpers
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    slv = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e, input string m);
    apb(0, a, 0);
    chk(q === e, m);
  endtask
  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Vector of on-chip request bit i
  function automatic logic [6:0] pv(input int i);
    if (i < 3) return 7'(24 + i);
    if (i == 3) return 7'h1C;
    if (i < 9) return 7'(28 + i);
    if (i < 22) return 7'(31 + i);
    if (i < 30) return 7'(34 + i);
    if (i < 34) return 7'(42 + i);
    return 7'(46 + i);
  endfunction

  // ====
  // Scenarios
  task t_regs;
    rd(OFS_MASK, 32'h0, "mask reset");
    rd(OFS_PRIO_BASE, 32'h77, "priority reset");
    apb(0, 12'h040, 0);
    chk(slv === 1'b1 && q === 32'h0, "unmapped");
  endtask
  task t_vectors;
    logic [15:0] e;
    for (int i = 0; i < 50; i++) begin
      adv <= i[0];
      ext <= (i < 8) ? 8'h1 << i : 8'h0;
      preq <= (i >= 8) ? 42'h1 << (i - 8) : '0;
      wt(5);
      e = (i < 8) ? 16'(16 + i) : 16'(pv(i - 8));
      chk(grant.req === 1'b1, "request");
      chk(grant.vec === e[6:0], "vector");
      chk(grant.addr === (adv ? e * 4 : e * 2), "vector address");
    end
    ext <= 0;
    adv <= 0;
  endtask
  task t_mask0;
    preq <= 42'h2;
    condition_code_register <= 1;
    wt(5);
    chk(grant.req === 1'b0, "mask bit ignored");
    nmi_pin <= 1;
    wt(5);
    chk(grant.nmi === 1'b1 && grant.vec === 7'h07, "nmi");
    nmi_pin <= 0;
    condition_code_register <= 0;
    wt(5);
    chk(grant.vec === 7'h19, "unmasked");
  endtask
  task t_mode2;
    apb(1, OFS_SYSCTL, 32'h2);
    apb(1, 12'h018, 32'h73);
    apb(1, 12'h01C, 32'h55);
    rd(12'h01C, 32'h55, "priority write");
    preq <= 42'h7;
    lvl <= 5;
    wt(5);
    chk(grant.req === 1'b0, "level equal to mask");
    lvl <= 4;
    condition_code_register <= 1;
    wt(5);
    chk(grant.vec === 7'h19 && grant.level === 3'h5, "tie");
    rd(OFS_CURRENT, 32'h0000_2A64, "current view");
    lvl <= 2;
    wt(5);
    chk(grant.vec === 7'h19 && grant.level === 3'h5, "level order");
  endtask
  task t_badmode;
    apb(1, OFS_MASK, 32'h2);
    for (int m = 1; m < 4; m += 2) begin
      apb(1, OFS_SYSCTL, 32'(m));
      rd(OFS_SYSCTL, 32'h2, "refused mode");
      chk(irq === 1'b1, "irq raised");
    end
    apb(1, OFS_MASK, 32'h0);
    chk(irq === 1'b0, "irq masked");
    apb(1, OFS_STATUS, 32'h2);
    apb(1, OFS_MASK, 32'h2);
    chk(irq === 1'b0, "irq cleared");
    ack_en <= 1;
    wt(4);
    apb(0, OFS_STATUS, 0);
    chk(q[0] === 1'b1, "ack status");
    nmi_pin <= 1;
    wt(5);
    nmi_pin <= 0;
    wt(5);
    apb(0, OFS_STATUS, 0);
    chk(q[2:0] === 3'h5, "nmi ack status");
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_regs;
    t_vectors;
    t_mask0;
    t_mode2;
    t_badmode;
    end_of_test;
  end
  initial begin
    #50000;
    err_total++;
    end_of_test;
  end
endmodule
